// ===== include/blhc_pkg.sv
`default_nettype none
package blhc_pkg;
   localparam int unsigned ADDR_W       = 32;
   localparam int unsigned PRIV_W       = 2;
   localparam int unsigned VEC_W        = 8;
   localparam int unsigned INIT_CYC_DEF = 16;
   localparam logic        LOCK_RST     = 1'b0;
   localparam logic        ACK_RST      = 1'b0;

   typedef struct packed {
      logic              valid;
      logic              locked;
      logic              unaligned;
      logic [ADDR_W-1:0] addr;
   } blhc_req_type;

   typedef struct packed {
      logic [PRIV_W-1:0] current_privilege_level;
      logic [PRIV_W-1:0] io_privilege_level;
      logic              legacy_chk;
   } blhc_priv_type;

   typedef enum logic [5:0] {
      ST_INIT = 6'h01,
      ST_IDLE = 6'h02,
      ST_XFER = 6'h04,
      ST_GAP  = 6'h08,
      ST_HELD = 6'h10,
      ST_INTA = 6'h20
   } blhc_state_type;
endpackage
`default_nettype wire

// ===== src/blhc_priv_chk.sv
`timescale 1ns/10ps
`default_nettype none
module blhc_priv_chk
   import blhc_pkg::*;
(
   input  wire logic          i_locked,
   input  wire blhc_priv_type i_priv,
   output logic              o_fault
);
   // default mode never compares privilege levels
   // legacy mode faults when a locked op's current level exceeds io level
   always_comb begin
      o_fault = i_priv.legacy_chk & i_locked &
                (i_priv.current_privilege_level > i_priv.io_privilege_level);
   end
endmodule
`default_nettype wire

// ===== src/blhc_ctrl.sv
// Overview of operation
// - locked op owns whole bus, wider than operand
// - default mode: lock prefix never privilege checked
// - legacy mode: fault if locked and current above io level
// - acknowledge holds lock until vector taken
// - hold grantable between unaligned operand parts, unless the op is locked
// - hold honoured during reset initialization
`timescale 1ns/10ps
`default_nettype none
module blhc_ctrl
   import blhc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = INIT_CYC_DEF
)(
   input  wire logic              i_mclk,
   input  wire logic              i_rst_b,
   input  wire blhc_req_type      i_req,
   input  wire blhc_priv_type     i_priv,
   input  wire logic              i_inta_lock_en,
   input  wire logic              i_intr,
   input  wire logic [VEC_W-1:0]  i_data,
   input  wire logic              i_vec_strobe,
   input  wire logic              i_bus_done,
   input  wire logic              i_hold,
   output logic                   o_req_ready,
   output logic                   o_fault,
   output logic                   o_bus_start,
   output logic                   o_bus_part,
   output logic [ADDR_W-1:0]      o_bus_addr,
   output logic                   o_lock,
   output logic                   o_hold_ack,
   output logic [VEC_W-1:0]       o_vector,
   output logic                   o_vector_valid,
   output logic                   o_init_done
);
   localparam int unsigned CNT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_CYCLES - 1);

   // a zero-length init period would leave the counter without a last value
   if (INIT_CYCLES < 1) begin : g_bad_init
      $error("INIT_CYCLES must be at least 1");
   end

   blhc_state_type    st_q,    st_d;
   blhc_state_type    ret_q,   ret_d;
   logic [CNT_W-1:0]  cnt_q,   cnt_d;
   logic              init_q,  init_d;
   logic              lkd_q,   lkd_d;
   logic              unal_q,  unal_d;
   logic              part_q,  part_d;
   logic              ilk_q,   ilk_d;
   logic [ADDR_W-1:0] addr_q,  addr_d;
   logic              rdy_q,   rdy_d;
   logic              flt_q,   flt_d;
   logic              start_q, start_d;
   logic              lock_q,  lock_d;
   logic              ack_q,   ack_d;
   logic [VEC_W-1:0]  vec_q,   vec_d;
   logic              vval_q,  vval_d;
   logic              fault_now;
   logic              take;

   blhc_priv_chk u_priv (
      .i_locked (i_req.locked),
      .i_priv   (i_priv),
      .o_fault  (fault_now)
   );

   // ready is registered, so the cycle it shows must not re-take
   assign take = i_req.valid & ~rdy_q & ~flt_q;

   always_comb begin
      st_d    = st_q;
      ret_d   = ret_q;
      cnt_d   = cnt_q;
      init_d  = init_q;
      lkd_d   = lkd_q;
      unal_d  = unal_q;
      part_d  = part_q;
      ilk_d   = ilk_q;
      addr_d  = addr_q;
      rdy_d   = 1'b0;
      flt_d   = 1'b0;
      start_d = 1'b0;
      vec_d   = vec_q;
      vval_d  = 1'b0;
      // init timer runs on even while the bus is handed away
      if (!init_q) begin
         if (cnt_q == CNT_LAST) begin
            init_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
      unique case (st_q)
         ST_INIT: begin
            if (i_hold) begin
               st_d  = ST_HELD;
               ret_d = ST_INIT;
            end else if (init_q) begin
               st_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (i_hold) begin
               st_d  = ST_HELD;
               ret_d = ST_IDLE;
            end else if (i_intr) begin
               st_d  = ST_INTA;
               ilk_d = i_inta_lock_en;
            end else if (take) begin
               if (fault_now) begin
                  flt_d = 1'b1;
                  rdy_d = 1'b1;
               end else begin
                  // whole bus locked: covers the operand and more
                  st_d    = ST_XFER;
                  lkd_d   = i_req.locked;
                  unal_d  = i_req.unaligned;
                  addr_d  = i_req.addr;
                  part_d  = 1'b0;
                  start_d = 1'b1;
               end
            end
         end
         ST_XFER: begin
            if (i_bus_done) begin
               if (unal_q && !part_q) begin
                  st_d = ST_GAP;
               end else begin
                  st_d  = ST_IDLE;
                  lkd_d = 1'b0;
                  rdy_d = 1'b1;
               end
            end
         end
         ST_GAP: begin
            if (i_hold && !lkd_q) begin
               st_d  = ST_HELD;
               ret_d = ST_GAP;
            end else begin
               st_d    = ST_XFER; // locked: hold deferred
               part_d  = 1'b1;
               start_d = 1'b1;
            end
         end
         ST_HELD: begin
            if (!i_hold) begin
               st_d = ret_q;
            end
         end
         ST_INTA: begin
            if (i_vec_strobe) begin
               vec_d  = i_data;
               vval_d = 1'b1;
               st_d   = ST_IDLE;
               ilk_d  = 1'b0;
            end else if (i_hold && !ilk_q) begin
               st_d  = ST_HELD;
               ret_d = ST_INTA;
            end
         end
      endcase
      lock_d = ((st_d == ST_XFER || st_d == ST_GAP) && lkd_d) ||
               (st_d == ST_INTA && ilk_d);
      ack_d  = (st_d == ST_HELD);
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         st_q    <= ST_INIT;
         ret_q   <= ST_IDLE;
         cnt_q   <= '0;
         init_q  <= 1'b0;
         lkd_q   <= 1'b0;
         unal_q  <= 1'b0;
         part_q  <= 1'b0;
         ilk_q   <= 1'b0;
         addr_q  <= '0;
         rdy_q   <= 1'b0;
         flt_q   <= 1'b0;
         start_q <= 1'b0;
         lock_q  <= LOCK_RST;
         ack_q   <= ACK_RST;
         vec_q   <= '0;
         vval_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         ret_q   <= ret_d;
         cnt_q   <= cnt_d;
         init_q  <= init_d;
         lkd_q   <= lkd_d;
         unal_q  <= unal_d;
         part_q  <= part_d;
         ilk_q   <= ilk_d;
         addr_q  <= addr_d;
         rdy_q   <= rdy_d;
         flt_q   <= flt_d;
         start_q <= start_d;
         lock_q  <= lock_d;
         ack_q   <= ack_d;
         vec_q   <= vec_d;
         vval_q  <= vval_d;
      end
   end

   assign o_req_ready    = rdy_q;
   assign o_fault        = flt_q;
   assign o_bus_start    = start_q;
   assign o_bus_part     = part_q;
   assign o_bus_addr     = addr_q;
   assign o_lock         = lock_q;
   assign o_hold_ack     = ack_q;
   assign o_vector       = vec_q;
   assign o_vector_valid = vval_q;
   assign o_init_done    = init_q;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   AST_LOCK_SECOND_PART: assert property (
      (o_bus_start && o_bus_part && lkd_q) |-> o_lock)
      else $error("locked op lost lock on second part");
   AST_DEFAULT_NO_FAULT: assert property (
      (st_q == ST_IDLE && !i_hold && !i_intr && take &&
       !i_priv.legacy_chk) |=> (!o_fault && o_bus_start))
      else $error("fault raised in default lock mode");
   AST_LEGACY_FAULT: assert property (
      (st_q == ST_IDLE && !i_hold && !i_intr && take &&
       i_priv.legacy_chk && i_req.locked &&
       i_priv.current_privilege_level > i_priv.io_privilege_level) |=> (o_fault && !o_bus_start))
      else $error("legacy privilege fault missing");
   AST_INTA_LOCK_HOLDS: assert property (
      (st_q == ST_INTA && ilk_q && !i_vec_strobe) |=> o_lock)
      else $error("lock dropped before vector taken");
   AST_VECTOR_CAPTURE: assert property (
      (st_q == ST_INTA && i_vec_strobe) |=>
      (o_vector_valid && o_vector == $past(i_data) && !o_lock))
      else $error("vector not captured from data bus");
   AST_GAP_HOLD: assert property (
      (st_q == ST_GAP && i_hold && !lkd_q) |=>
      (o_hold_ack && !o_bus_start) ##1 (st_q == ST_HELD))
      else $error("hold not granted between operand parts");
   AST_INIT_HOLD: assert property (
      (st_q == ST_INIT && i_hold) |=> o_hold_ack)
      else $error("hold not honoured during initialization");
   AST_NO_GRANT_LOCKED: assert property (
      o_lock |-> !o_hold_ack)
      else $error("hold granted while bus locked");
   AST_HOLD_RELEASE: assert property (
      (o_hold_ack && !i_hold) |=> !o_hold_ack)
      else $error("bus not reclaimed after hold release");

   COV_GAP_HOLD:  cover property (st_q == ST_GAP ##1 st_q == ST_HELD);
   COV_INTA_LOCK: cover property (o_lock && st_q == ST_INTA ##[1:8]
                                  o_vector_valid);
   COV_FAULT:     cover property (o_fault);
   COV_INIT_HOLD: cover property (st_q == ST_INIT && o_hold_ack);
endmodule
`default_nettype wire

// ===== dv/blhc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module blhc_far_model
   import blhc_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_b,
   input  wire logic             i_bus_start,
   input  wire logic             i_slow,
   input  wire logic             i_irq_go,
   input  wire logic [VEC_W-1:0] i_vec,
   input  wire logic             i_vector_valid,
   output logic                  o_intr,
   output logic [VEC_W-1:0]      o_data,
   output logic                  o_vec_strobe,
   output logic                  o_bus_done
);
   logic [3:0] bus_q;
   logic [3:0] ack_q;
   initial begin
      {o_intr, o_data, o_vec_strobe, o_bus_done, bus_q, ack_q} = '0;
   end
   always @(posedge i_mclk) begin
      if (!i_rst_b) begin
         {o_intr, o_vec_strobe, o_bus_done, bus_q, ack_q} <= '0;
         o_data <= ~o_data;
      end else begin
         if (i_bus_start) begin
            bus_q      <= i_slow ? 4'h4 : 4'h1;
            o_bus_done <= 1'b0;
         end else if (bus_q != 4'h0) begin
            bus_q      <= bus_q - 4'h1;
            o_bus_done <= (bus_q == 4'h1);
         end else begin
            o_bus_done <= 1'b0;
         end
         if (i_irq_go) begin
            o_intr <= 1'b1;
            ack_q  <= 4'h8;
         end else if (ack_q == 4'h1) begin
            // request ends with the handover, else it would be taken twice
            o_intr       <= 1'b0;
            o_vec_strobe <= 1'b1;
            ack_q        <= 4'h0;
         end else if (ack_q != 4'h0) begin
            ack_q <= ack_q - 4'h1;
         end else if (i_vector_valid) begin
            o_vec_strobe <= 1'b0;
         end
         if (ack_q == 4'h1 && !i_irq_go) begin
            o_data <= i_vec;
         end else if (!o_vec_strobe) begin
            // released bus keeps toggling, alternating the old vector with its inverse
            o_data <= ~o_data;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/bus_lock_and_hold_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module bus_lock_and_hold_control_bench;
   import blhc_pkg::*;
   logic              i_mclk, i_rst_b, i_inta_lock_en, i_intr, i_hold;
   logic              i_vec_strobe, i_bus_done, slow, irq_go;
   blhc_req_type      i_req;
   blhc_priv_type     i_priv;
   logic [VEC_W-1:0]  i_data, vec, o_vector;
   logic [ADDR_W-1:0] o_bus_addr;
   logic              o_req_ready, o_fault, o_bus_start, o_bus_part;
   logic              o_lock, o_hold_ack, o_vector_valid, o_init_done;
   logic [15:0]       seed_q, r;
   int                num_errors = 0, compares = 0, cyc = 0, k;

   blhc_ctrl #(.INIT_CYCLES(4)) blhc_ctrl_inst (.i_mclk, .i_rst_b, .i_req,
      .i_priv, .i_inta_lock_en, .i_intr, .i_data, .i_vec_strobe, .i_bus_done,
      .i_hold, .o_req_ready, .o_fault, .o_bus_start, .o_bus_part, .o_bus_addr,
      .o_lock, .o_hold_ack, .o_vector, .o_vector_valid, .o_init_done);
   blhc_far_model blhc_far_model_inst (.i_mclk, .i_rst_b,
      .i_bus_start(o_bus_start), .i_slow(slow), .i_irq_go(irq_go),
      .i_vec(vec), .i_vector_valid(o_vector_valid), .o_intr(i_intr),
      .o_data(i_data), .o_vec_strobe(i_vec_strobe), .o_bus_done(i_bus_done));

   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic do_req(input logic lk, un, lg, input logic [1:0] cp, io,
                         input logic dma, sl, input logic [31:0] ad);
      int n, starts, acks;
      starts = 0;
      acks = 0;
      i_req <= '{1'b1, lk, un, ad};
      i_priv <= '{cp, io, lg};
      slow <= sl;
      for (n = 0; n < 60 && o_req_ready !== 1'b1; n++) begin
         @(posedge i_mclk);
         if (o_bus_start === 1'b1) begin
            starts++;
            check(o_lock, lk);
            check(o_bus_addr, ad);
            check(o_bus_part, starts == 2);
         end
         if (o_hold_ack === 1'b1) begin
            check(o_lock, 1'b0);
         end
         // hold asked for the gap only; one grant counted per request
         if (o_bus_start === 1'b1 && starts == 1 && un && dma) begin
            i_hold <= 1'b1;
         end else if (i_hold === 1'b1 &&
                      (o_hold_ack === 1'b1 || o_bus_start === 1'b1)) begin
            acks += int'(o_hold_ack === 1'b1);
            i_hold <= 1'b0;
         end
      end
      i_req <= '0;
      check(o_req_ready, 1'b1);
      check(o_fault, lg & lk & (cp > io));
      check(starts, (lg & lk & (cp > io)) ? 0 : (un ? 2 : 1));
      check(acks, dma & un & !lk);
      repeat (3) @(posedge i_mclk);
   endtask

   task automatic do_irq(input logic en, input logic [7:0] v);
      int n, locks, acks;
      logic drop;
      locks = 0;
      acks = 0;
      drop = 1'b0;
      i_inta_lock_en <= en;
      irq_go <= 1'b1;
      vec <= v;
      @(posedge i_mclk);
      irq_go <= 1'b0;
      for (n = 0; n < 40 && o_vector_valid !== 1'b1; n++) begin
         @(posedge i_mclk);
         if (o_lock === 1'b1) begin
            locks++;
         end else if (locks > 0 && o_vector_valid !== 1'b1) begin
            drop = 1'b1;
         end
         if (o_hold_ack === 1'b1) begin
            check(o_lock, 1'b0);
         end
         if (n == 3) begin
            i_hold <= 1'b1;
         end else if (o_hold_ack === 1'b1 && i_hold === 1'b1) begin
            acks++;
            i_hold <= 1'b0;
         end
      end
      i_hold <= 1'b0;
      check(o_vector_valid, 1'b1);
      check(o_vector, v);
      check(locks > 0, en);
      check(drop, 1'b0);
      check(acks, !en);
      repeat (3) @(posedge i_mclk);
   endtask

   initial begin
      {i_rst_b, i_inta_lock_en, i_hold, slow, irq_go} = '0;
      i_req = '0;
      i_priv = '0;
      vec = '0;
      seed_q = 16'h005f;
      repeat (6) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      i_hold <= 1'b1;
      repeat (2) @(posedge i_mclk);
      check(o_hold_ack, 1'b1);
      check(o_init_done, 1'b0);
      i_hold <= 1'b0;
      for (k = 0; k < 30 && o_init_done !== 1'b1; k++) @(posedge i_mclk);
      repeat (2) @(posedge i_mclk);
      do_req(1, 0, 1, 2'h3, 2'h2, 0, 0, 32'hffff_fffc);
      do_req(1, 0, 1, 2'h2, 2'h2, 0, 0, 32'h0000_0010);
      do_req(1, 1, 0, 2'h3, 2'h0, 1, 1, 32'h0000_0ffe);
      do_req(0, 1, 0, 2'h0, 2'h0, 1, 1, 32'h8000_0003);
      do_req(0, 1, 1, 2'h3, 2'h0, 1, 0, 32'h1234_5679);
      do_irq(1'b1, 8'ha5);
      do_irq(1'b0, 8'h5a);
      for (k = 0; k < 24; k++) begin
         seed_q = lfsr(seed_q);
         r = seed_q;
         seed_q = lfsr(seed_q);
         do_req(r[0], r[1], r[2], r[4:3], r[6:5], r[7], r[8], {r, seed_q});
         if (k % 6 == 5) do_irq(r[9], seed_q[7:0]);
      end
      stop_test();
   end
endmodule
`default_nettype wire
